// ==== include/dcg_pkg.sv ====
// dcg_pkg: constants, types and register map of the dual oscillator clock generator.
// assumes a single mclk domain; oscillators are sampled as ordinary inputs.
package dcg_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] DCG_ADDR_CLKSRC = 4'h0;
    localparam logic [3:0] DCG_ADDR_OSCCTL = 4'h1;
    localparam logic [3:0] DCG_ADDR_RELOAD = 4'h2;
    localparam logic [3:0] DCG_ADDR_PWRCTL = 4'h3;
    localparam logic [3:0] DCG_ADDR_SPEED = 4'h4;
    localparam logic [3:0] DCG_ADDR_STATUS = 4'h5;

    // field positions
    localparam int DCG_BIT_CKS = 0;
    localparam int DCG_BIT_PRI_EN = 0;
    localparam int DCG_BIT_SEC_EN = 1;
    localparam int DCG_BIT_T0SEL = 2;
    localparam int DCG_BIT_IDLE = 0;
    localparam int DCG_BIT_PWD = 1;
    localparam int DCG_BIT_X2 = 0;

    // reload reset value, all-ones bypass value and span
    localparam logic [7:0] DCG_RELOAD_RST = 8'hFF;
    localparam logic [7:0] DCG_RELOAD_MAX = 8'hFF;
    localparam logic [8:0] DCG_RELOAD_SPAN = 9'h0FF;

    typedef enum logic [1:0] {
        DCG_RUN,
        DCG_IDLE,
        DCG_PWD
    } dcg_mode_e;

    // register port request carrier
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dcg_req_s;

    // wake-up events from the interrupt side
    typedef struct packed {
        logic any_irq;
        logic ext_irq;
        logic kbd_irq;
    } dcg_wake_s;

endpackage

// ==== core/dcg_clock_gen.sv ====
// dcg_clock_gen: source select, prescaler, double speed, idle and power-down control.
// assumes oscillators and timer pin are asynchronous levels sampled by mclk,
// and that the interrupt controller reports wake events on mclk.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

module dcg_clock_gen
    import dcg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire dcg_req_s req,
    output logic [7:0] rdata,
    input wire dcg_wake_s wake,
    input wire logic startup_source_fuse,
    input wire logic primary_clock_source,
    input wire logic secondary_clock_source,
    input wire logic timer_zero_input_pin,
    input wire logic sub_clock,
    output logic primary_stop_signal,
    output logic secondary_stop_signal,
    output logic cpu_clk,
    output logic periph_clk,
    output logic timer_zero_clk,
    output logic cpu_clk_en,
    output logic [1:0] mode_state
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers; first stage only feeds second stage

    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    // left unreset on purpose: the fuse level must already stand in the second
    // stage when reset releases, or the configuration load would see zero
    always_ff @(posedge mclk) begin
        sync1_r <= {sub_clock, timer_zero_input_pin, secondary_clock_source,
                    primary_clock_source, startup_source_fuse};
        sync2_r <= sync1_r;
    end
    logic fuse_s;
    logic pri_s;
    logic sec_s;
    logic t0pin_s;
    logic sub_s;
    assign fuse_s = sync2_r[0];
    assign pri_s = sync2_r[1];
    assign sec_s = sync2_r[2];
    assign t0pin_s = sync2_r[3];
    assign sub_s = sync2_r[4];

    ////////////////////////////////////////////////////////////////////////////
    // fuse capture: reset configuration is applied in the cycle after release

    logic cfg_pend_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_pend_r <= 1'b1;
        end else begin
            cfg_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator control register

    logic cks_r;
    logic pri_en_r;
    logic sec_en_r;
    logic t0sel_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cks_r <= 1'b1;
            pri_en_r <= 1'b1;
            sec_en_r <= 1'b0;
            t0sel_r <= 1'b0;
        end else if (cfg_pend_r) begin
            // fuse sampled after release, never under reset
            cks_r <= fuse_s;
            pri_en_r <= fuse_s;
            sec_en_r <= ~fuse_s;
        end else if (req.wr) begin
            // idle or power-down exit never touches these
            if (req.addr == DCG_ADDR_CLKSRC) begin
                cks_r <= req.wdata[DCG_BIT_CKS];
            end
            if (req.addr == DCG_ADDR_OSCCTL) begin
                // invalid combinations are software's burden
                pri_en_r <= req.wdata[DCG_BIT_PRI_EN];
                sec_en_r <= req.wdata[DCG_BIT_SEC_EN];
                t0sel_r <= req.wdata[DCG_BIT_T0SEL];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler reload and double speed request

    logic [7:0] reload_r;
    logic x2_req_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reload_r <= DCG_RELOAD_RST;
            x2_req_r <= 1'b0;
        end else if (req.wr && req.addr == DCG_ADDR_RELOAD) begin
            reload_r <= req.wdata; // any value FFh..00h
        end else if (req.wr && req.addr == DCG_ADDR_SPEED) begin
            x2_req_r <= req.wdata[DCG_BIT_X2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power control: idle and power-down request bits

    logic idle_req_r;
    logic pwd_req_r;
    logic pwd_wr;
    logic idle_wr;
    assign pwd_wr = req.wr && req.addr == DCG_ADDR_PWRCTL && req.wdata[DCG_BIT_PWD];
    assign idle_wr = req.wr && req.addr == DCG_ADDR_PWRCTL && req.wdata[DCG_BIT_IDLE];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pwd_req_r <= 1'b0;
        end else if (pwd_wr) begin
            pwd_req_r <= 1'b1; // set wins over a same-cycle wake
        end else if (pwd_req_r && (wake.ext_irq || wake.kbd_irq)) begin
            pwd_req_r <= 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            idle_req_r <= 1'b0;
        end else if (idle_wr) begin
            idle_req_r <= 1'b1;
        end else if (idle_req_r && !pwd_req_r && wake.any_irq) begin
            idle_req_r <= 1'b0;
        end
    end

    // power-down takes priority over idle when both bits are set
    dcg_mode_e mode;
    always_comb begin
        case ({pwd_req_r, idle_req_r})
            2'b00: mode = DCG_RUN;
            2'b01: mode = DCG_IDLE;
            2'b10: mode = DCG_PWD;
            2'b11: mode = DCG_PWD;
            default: mode = DCG_RUN;
        endcase
    end
    assign mode_state = mode;

    ////////////////////////////////////////////////////////////////////////////
    // stop signals; enables are kept so the entry oscillator restarts on wake

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            primary_stop_signal <= 1'b0;
            secondary_stop_signal <= 1'b1;
        end else begin
            primary_stop_signal <= pwd_req_r | ~pri_en_r;
            secondary_stop_signal <= pwd_req_r | ~sec_en_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // glitch-free source mux: drop old side on its low phase, then raise new

    logic sel_pri_r;
    logic sel_sec_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sel_pri_r <= 1'b1;
            sel_sec_r <= 1'b0;
        end else begin
            // a side only changes while its own clock is low
            if (!pri_s) begin
                sel_pri_r <= cks_r && !sel_sec_r;
            end
            if (!sec_s) begin
                sel_sec_r <= !cks_r && !sel_pri_r;
            end
        end
    end
    logic osc_mux;
    assign osc_mux = (sel_pri_r & pri_s) | (sel_sec_r & sec_s);

    ////////////////////////////////////////////////////////////////////////////
    // divide-by-two stage and double speed validation

    logic osc_d_r;
    logic half_r;
    logic x2_r;
    logic rise;
    assign rise = osc_mux & ~osc_d_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            osc_d_r <= 1'b0;
            half_r <= 1'b0;
        end else begin
            osc_d_r <= osc_mux;
            if (rise) begin
                half_r <= ~half_r;
            end
        end
    end
    // x2 is only accepted when the half-rate clock rises
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            x2_r <= 1'b0;
        end else if (rise && !half_r) begin
            x2_r <= x2_req_r;
        end
    end

    // one tick per period of the stage output: undivided or halved
    logic tick;
    assign tick = x2_r ? rise : (rise && half_r);

    ////////////////////////////////////////////////////////////////////////////
    // reload prescaler: period 255-reload ticks per half cycle of output

    logic [7:0] pcnt_r;
    logic pclk_r;
    logic [7:0] span;
    assign span = 8'(DCG_RELOAD_SPAN - {1'b0, reload_r});
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pcnt_r <= 8'h00;
            pclk_r <= 1'b0;
        end else if (reload_r == DCG_RELOAD_MAX) begin
            // all ones: stage output passes straight through
            pcnt_r <= 8'h00;
            pclk_r <= x2_r ? osc_mux : half_r;
        end else if (tick) begin
            // half period of 255-reload ticks gives /2 or /4 times span
            if (pcnt_r + 8'h01 >= span) begin
                pcnt_r <= 8'h00;
                pclk_r <= ~pclk_r;
            end else begin
                pcnt_r <= pcnt_r + 8'h01;
            end
        end
    end

    // with all ones the level follows the oscillator in double speed and the
    // halved stage otherwise, one mclk late; pclk_r is the sampled clock level

    ////////////////////////////////////////////////////////////////////////////
    // gated outputs: cpu stops in idle, cpu and peripheral clocks stop in power-down; timer zero clock is never gated

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cpu_clk <= 1'b0;
            periph_clk <= 1'b0;
            cpu_clk_en <= 1'b1;
        end else begin
            cpu_clk <= pclk_r && mode == DCG_RUN;
            periph_clk <= pclk_r && mode != DCG_PWD;
            cpu_clk_en <= mode == DCG_RUN;
        end
    end

    // timer zero clock source
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            timer_zero_clk <= 1'b0;
        end else begin
            timer_zero_clk <= t0sel_r ? sub_s : t0pin_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after the strobe

    logic [7:0] rd_nxt;
    always_comb begin
        case (req.addr)
            DCG_ADDR_CLKSRC: rd_nxt = {7'h00, cks_r};
            DCG_ADDR_OSCCTL: rd_nxt = {5'h00, t0sel_r, sec_en_r, pri_en_r};
            DCG_ADDR_RELOAD: rd_nxt = reload_r;
            DCG_ADDR_PWRCTL: rd_nxt = {6'h00, pwd_req_r, idle_req_r};
            DCG_ADDR_SPEED: rd_nxt = {7'h00, x2_req_r};
            DCG_ADDR_STATUS: rd_nxt = {3'h0, x2_r, sel_sec_r, sel_pri_r, mode};
            default: rd_nxt = 8'h00;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            rdata <= rd_nxt;
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule

// ==== bench/dcg_clock_gen_assertions.sv ====
// dcg_clock_gen_assertions: port-level checks of the clock generator.
// assumes one mclk domain; bound onto every dcg_clock_gen instance.
`timescale 1ns/1ps

module dcg_clock_gen_assertions
    import dcg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire dcg_req_s req,
    input wire dcg_wake_s wake,
    input wire logic primary_stop_signal,
    input wire logic secondary_stop_signal,
    input wire logic cpu_clk_en,
    input wire logic [1:0] mode_state
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // a power control write this cycle; set wins over a wake clear
    logic pw_wr;
    assign pw_wr = req.wr && req.addr == DCG_ADDR_PWRCTL;

    ////////////////////////////////////////
    property p_idle_in;
        pw_wr && req.wdata[1:0] == 2'b01 && mode_state == DCG_RUN |=> mode_state == DCG_IDLE;
    endproperty
    a_idle_in: assert property (p_idle_in) else $error("idle not entered");
    property p_pd_in;
        pw_wr && req.wdata[1] |=> mode_state == DCG_PWD;
    endproperty
    a_pd_in: assert property (p_pd_in) else $error("power-down not entered");
    property p_idle_out;
        mode_state == DCG_IDLE && wake.any_irq && !pw_wr |=> mode_state == DCG_RUN;
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("idle not left");
    property p_pd_out;
        mode_state == DCG_PWD && (wake.ext_irq || wake.kbd_irq) && !pw_wr |=> mode_state == DCG_RUN;
    endproperty
    a_pd_out: assert property (p_pd_out) else $error("power-down not left");
    property p_pd_hold;
        mode_state == DCG_PWD && !wake.ext_irq && !wake.kbd_irq |=> mode_state == DCG_PWD;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power-down left early");
    property p_pri_stop;
        mode_state == DCG_PWD |=> primary_stop_signal;
    endproperty
    a_pri_stop: assert property (p_pri_stop) else $error("primary runs in pd");
    property p_sec_stop;
        mode_state == DCG_PWD |=> secondary_stop_signal;
    endproperty
    a_sec_stop: assert property (p_sec_stop) else $error("secondary runs in pd");
    // two cycles allow for the registered enable
    property p_cpu_off;
        mode_state != DCG_RUN [*2] |-> !cpu_clk_en;
    endproperty
    a_cpu_off: assert property (p_cpu_off) else $error("cpu clock on in low power");
    c_idle: cover property (mode_state == DCG_IDLE ##1 mode_state == DCG_RUN);
    c_pd: cover property (mode_state == DCG_PWD ##1 mode_state == DCG_PWD);
    c_kbd: cover property (mode_state == DCG_PWD && wake.kbd_irq);
endmodule

bind dcg_clock_gen dcg_clock_gen_assertions i_chk (
    .mclk(mclk), .sys_rst(sys_rst), .req(req), .wake(wake),
    .primary_stop_signal(primary_stop_signal), .secondary_stop_signal(secondary_stop_signal),
    .cpu_clk_en(cpu_clk_en), .mode_state(mode_state)
);

// ==== bench/dcg_osc_model.sv ====
// dcg_osc_model: behavioural oscillator pad, halted by its stop input.
// assumes stop comes from the clock generator; half period in ns.
`timescale 1ns/1ps

module dcg_osc_model #(
    parameter int HALF_NS = 40
) (
    input wire logic stop,
    output logic osc
);
    // a halted oscillator stands low rather than freezing mid-phase
    initial osc = 1'b0;
    always begin
        #(HALF_NS);
        osc = stop ? 1'b0 : ~osc;
    end
endmodule

// ==== bench/tb_dcg_clock_gen.sv ====
// tb_dcg_clock_gen: register-port tests of the clock generator.
// assumes oscillator models on both pads and a 100 MHz mclk.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end

module tb_dcg_clock_gen import dcg_pkg::*;;
    logic mclk, sys_rst, fuse, t0_pin, sub_clk, pri_osc, sec_osc;
    logic pri_stop, sec_stop, cpu_clk, cpu_clk_en, t0_clk, periph_clk;
    int nc, np;
    logic [7:0] rdata;
    logic [1:0] mode;
    dcg_req_s req;
    dcg_wake_s wake;
    int error_cnt, n_compared;

    dcg_clock_gen i_dut (
        .mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .wake(wake),
        .startup_source_fuse(fuse), .primary_clock_source(pri_osc),
        .secondary_clock_source(sec_osc), .timer_zero_input_pin(t0_pin), .sub_clock(sub_clk),
        .primary_stop_signal(pri_stop), .secondary_stop_signal(sec_stop), .cpu_clk(cpu_clk),
        .periph_clk(periph_clk), .timer_zero_clk(t0_clk), .cpu_clk_en(cpu_clk_en),
        .mode_state(mode)
    );
    dcg_osc_model #(.HALF_NS(40)) i_pri (.stop(pri_stop), .osc(pri_osc));
    dcg_osc_model #(.HALF_NS(70)) i_sec (.stop(sec_stop), .osc(sec_osc));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge mclk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 `CHK(nm, e, rdata)
    endtask
    task automatic wake_up(input dcg_wake_s w);
        @(posedge mclk);
        wake <= w;
        @(posedge mclk);
        wake <= '0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    // fuse is set well ahead of the release so its synchroniser fills
    task automatic reset_dut(input logic f);
        @(posedge mclk);
        fuse <= f;
        sys_rst <= 1'b1;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic settle;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    // counts cpu and peripheral clock rises over 300 cycles, sampled after settling
    task automatic edges(output int c, output int p);
        logic pc;
        logic pp;
        c = 0;
        p = 0;
        pc = cpu_clk;
        pp = periph_clk;
        repeat (300) begin
            @(posedge mclk);
            #1;
            c += int'(cpu_clk && !pc);
            p += int'(periph_clk && !pp);
            pc = cpu_clk;
            pp = periph_clk;
        end
    endtask
    // counts cpu clock rises over 100 primary periods
    task automatic rate(input logic [7:0] rl, input logic x2);
        int n;
        int dv;
        logic prev;
        n = 0;
        prev = 1'b0;
        dv = (rl == 8'hFF) ? (x2 ? 1 : 2) : (x2 ? 2 : 4) * (255 - int'(rl));
        wr(DCG_ADDR_RELOAD, rl);
        wr(DCG_ADDR_SPEED, {7'h00, x2});
        repeat (40) @(posedge mclk);
        repeat (800) begin
            @(posedge mclk);
            #1;
            n += int'(cpu_clk && !prev);
            prev = cpu_clk;
        end
        `CHK("cpu clock edges", 1'b1, (n >= 100 / dv - 1 && n <= 100 / dv + 1))
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish;
    end

    initial begin
        sys_rst = 1'b1;
        fuse = 1'b1;
        req = '0;
        wake = '0;
        t0_pin = 1'b0;
        sub_clk = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        reset_dut(1'b1);
        rd(DCG_ADDR_CLKSRC, 8'h01, "cks");
        rd(DCG_ADDR_OSCCTL, 8'h01, "osc enables");
        rd(DCG_ADDR_RELOAD, 8'hFF, "reload");
        rd(4'hF, 8'h00, "unmapped");
        rd(DCG_ADDR_STATUS, 8'h04, "status");
        `CHK("stops", 2'b01, {pri_stop, sec_stop})
        $display("test reset done");
        rate(8'hFF, 1'b0);
        rate(8'hFF, 1'b1);
        rate(8'hFD, 1'b0);
        rate(8'hFD, 1'b1);
        rd(DCG_ADDR_STATUS, 8'h14, "status");
        wr(DCG_ADDR_RELOAD, 8'hFF);
        wr(DCG_ADDR_SPEED, 8'h00);
        $display("test divider done");
        // enable secondary before moving onto it, never stop the selected one
        wr(DCG_ADDR_OSCCTL, 8'h03);
        wr(DCG_ADDR_CLKSRC, 8'h00);
        rd(DCG_ADDR_CLKSRC, 8'h00, "cks");
        wr(DCG_ADDR_OSCCTL, 8'h02);
        settle;
        `CHK("stops", 2'b10, {pri_stop, sec_stop})
        wr(DCG_ADDR_PWRCTL, 8'h01);
        settle;
        `CHK("mode", DCG_IDLE, mode)
        `CHK("cpu enable", 1'b0, cpu_clk_en)
        `CHK("idle stops", 2'b10, {pri_stop, sec_stop})
        edges(nc, np);
        `CHK("cpu clock edges in idle", 0, nc)
        `CHK("periph clock runs in idle", 1'b1, np > 0)
        wake_up(3'b100);
        `CHK("mode", DCG_RUN, mode)
        rd(DCG_ADDR_PWRCTL, 8'h00, "power bits");
        rd(DCG_ADDR_OSCCTL, 8'h02, "osc enables");
        rd(DCG_ADDR_CLKSRC, 8'h00, "cks");
        rd(DCG_ADDR_STATUS, 8'h08, "status");
        $display("test idle done");
        wr(DCG_ADDR_PWRCTL, 8'h02);
        settle;
        `CHK("mode", DCG_PWD, mode)
        `CHK("stops", 2'b11, {pri_stop, sec_stop})
        edges(nc, np);
        `CHK("periph clock edges in pd", 0, np)
        wake_up(3'b100);
        `CHK("mode", DCG_PWD, mode)
        wake_up(3'b001);
        rd(DCG_ADDR_PWRCTL, 8'h00, "power bits");
        `CHK("stops", 2'b10, {pri_stop, sec_stop})
        wr(DCG_ADDR_PWRCTL, 8'h02);
        wake_up(3'b010);
        `CHK("mode", DCG_RUN, mode)
        `CHK("stops", 2'b10, {pri_stop, sec_stop})
        $display("test power-down done");
        // the unselected timer source is held opposite so a wrong route shows
        for (int s = 0; s < 2; s++) begin
            wr(DCG_ADDR_OSCCTL, {5'h00, s[0], 2'b10});
            t0_pin <= ~s[0];
            sub_clk <= s[0];
            settle;
            `CHK("timer clock", 1'b1, t0_clk)
        end
        $display("test timer source done");
        wr(DCG_ADDR_PWRCTL, 8'h02);
        reset_dut(1'b0);
        `CHK("mode", DCG_RUN, mode)
        rd(DCG_ADDR_CLKSRC, 8'h00, "cks");
        rd(DCG_ADDR_OSCCTL, 8'h02, "osc enables");
        $display("test fuse reset done");
        tally_and_finish;
    end
endmodule
